// File: dv/adc_sequencer_burst_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adc_sequencer_burst_control_bench;
    import asbc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, result_data, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, channel_range_pins;
    logic hw_mode_pin, burst_pin, seq_enable_pin, conversion_trigger;
    logic busy, conv_start, result_read, result_valid;
    logic [3:0] a_sel;
    logic [4:0] b_sel;
    logic [15:0] adc_a_data, adc_b_data;
    int mismatches, total_checks, busy_cnt;
    logic [8:0] seen_q[$];
    logic [4:0] row_idx[4];
    logic [9:0] row_val[4];

    always #2.5 hclk = ~hclk;
    assign hready = hreadyout;

    asbc_seq_top #(.CNT_W(12)) DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .hw_mode_pin(hw_mode_pin), .burst_pin(burst_pin),
        .seq_enable_pin(seq_enable_pin),
        .channel_range_pins(channel_range_pins),
        .conversion_trigger(conversion_trigger), .busy(busy),
        .conv_start(conv_start), .a_side_channel_select(a_sel),
        .b_side_channel_select(b_sel), .adc_a_data(adc_a_data),
        .adc_b_data(adc_b_data), .result_read(result_read),
        .result_valid(result_valid), .result_data(result_data));

    asbc_host_model host (.hclk(hclk), .conv_start(conv_start),
        .a_side_channel_select(a_sel), .b_side_channel_select(b_sel),
        .result_valid(result_valid), .result_data(result_data),
        .conversion_trigger(conversion_trigger),
        .result_read(result_read), .adc_a_data(adc_a_data),
        .adc_b_data(adc_b_data));

    always @(negedge hclk) begin
        if (busy === 1'b1) busy_cnt++;
        if (conv_start === 1'b1) seen_q.push_back({b_sel, a_sel});
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
        d = hrdata;
        check("response", 32'h0, 32'(hresp));
    endtask : ahb

    // one trigger, optionally a second edge and new range pins while busy
    task automatic do_conv(input int n, input int cyc, input logic extra);
        int i;
        seen_q.delete();
        busy_cnt = 0;
        host.trigger_edge();
        if (extra) begin
            @(posedge hclk);
            channel_range_pins <= 3'h0;
            host.trigger_edge();
        end
        i = 0;
        do begin
            @(negedge hclk);
            i++;
        end while (busy !== 1'b0 && i < 3000);
        check("result ready", 32'h1, 32'(result_valid));
        @(posedge hclk);
        check("busy cycles", 32'(cyc), 32'(busy_cnt));
        check("steps", 32'(n), 32'(seen_q.size()));
    endtask : do_conv

    task automatic pop_check(input logic [8:0] ba);
        logic [31:0] d;
        logic ok;
        host.pop_result(d, ok);
        check("result valid", 32'h1, 32'(ok));
        check("result", {12'hA5C, ba[3:0], 11'h3B1, ba[8:4]}, d);
    endtask : pop_check

    task automatic drained();
        @(negedge hclk);
        check("results left", 32'h0, 32'(result_valid));
        @(posedge hclk);
    endtask : drained

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        hw_mode_pin = 1'b0;
        burst_pin = 1'b0;
        seq_enable_pin = 1'b0;
        channel_range_pins = 3'h0;
        mismatches = 0;
        total_checks = 0;
        busy_cnt = 0;
        row_idx = '{5'h00, 5'h01, 5'h02, 5'h1F};
        row_val = '{10'h053, 10'h117, 10'h22F, 10'h011};
        repeat (8) @(posedge hclk);
        @(negedge hclk);
        check("busy in reset", 32'h0, 32'(busy));
        check("ready in reset", 32'h1, 32'(hreadyout));
        @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        ahb(1'b0, STAT_OFS, 32'h0, rd);
        check("status", 32'h0, rd);
        ahb(1'b1, 8'h40, 32'hFFFFFFFF, rd);
        ahb(1'b0, 8'h40, 32'h0, rd);
        check("unmapped", 32'h0, rd);
        for (int k = 0; k < 4; k++) begin
            ahb(1'b1, STACK_BASE + {row_idx[k], 2'b00}, 32'(row_val[k]), rd);
        end
        for (int k = 0; k < 4; k++) begin
            ahb(1'b0, STACK_BASE + {row_idx[k], 2'b00}, 32'h0, rd);
            check("stack entry", 32'(row_val[k]), rd);
        end
        do_conv(1, FIRST_CYC, 1'b0);
        check("step with sequencer off", 32'h0, 32'(seen_q[0]));
        pop_check(9'h000);
        ahb(1'b1, CFG_OFS, 32'h1, rd);
        for (int k = 0; k < 5; k++) begin
            do_conv(1, FIRST_CYC, 1'b0);
            check("step", 32'(row_val[k % 3][8:0]), 32'(seen_q[0]));
            pop_check(row_val[k % 3][8:0]);
        end
        ahb(1'b1, CFG_OFS, 32'h5, rd);
        ahb(1'b0, STAT_OFS, 32'h0, rd);
        check("pointer", 32'h0, 32'(rd[STAT_PTR_LSB +: 5]));
        ahb(1'b0, CFG_OFS, 32'h0, rd);
        check("config kept", 32'h1, rd);
        do_conv(1, FIRST_CYC, 1'b0);
        check("step after restart", 32'(row_val[0][8:0]), 32'(seen_q[0]));
        pop_check(row_val[0][8:0]);
        ahb(1'b1, CFG_OFS, 32'h7, rd);
        do_conv(3, FIRST_CYC + 2 * NEXT_CYC, 1'b1);
        for (int k = 0; k < 3; k++) begin
            check("burst step", 32'(row_val[k][8:0]), 32'(seen_q[k]));
            pop_check(row_val[k][8:0]);
        end
        drained();
        hresetn <= 1'b0;
        hw_mode_pin <= 1'b1;
        burst_pin <= 1'b1;
        seq_enable_pin <= 1'b1;
        channel_range_pins <= 3'h2;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        burst_pin <= 1'b0;
        seq_enable_pin <= 1'b0;
        ahb(1'b0, STAT_OFS, 32'h0, rd);
        check("hw flag", 32'h1, 32'(rd[STAT_HW_BIT]));
        check("hw burst", 32'h1, 32'(rd[STAT_BURST_BIT]));
        check("end pair", 32'h2, 32'(rd[STAT_END_LSB +: 3]));
        do_conv(3, FIRST_CYC + 2 * NEXT_CYC, 1'b1);
        for (int k = 0; k < 3; k++) begin
            check("hw step", 32'({k[4:0], k[3:0]}), 32'(seen_q[k]));
            pop_check({k[4:0], k[3:0]});
        end
        drained();
        do_conv(1, FIRST_CYC, 1'b0);
        check("hw pair zero", 32'h0, 32'(seen_q[0]));
        close_out();
    end

    initial begin
        #(5 * 20000);
        mismatches++;
        close_out();
    end
endmodule : adc_sequencer_burst_control_bench
`default_nettype wire

// File: dv/asbc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module asbc_host_model (
    input wire logic hclk,
    input wire logic conv_start,
    input wire logic [3:0] a_side_channel_select,
    input wire logic [4:0] b_side_channel_select,
    input wire logic result_valid,
    input wire logic [31:0] result_data,
    output logic conversion_trigger,
    output logic result_read,
    output logic [15:0] adc_a_data,
    output logic [15:0] adc_b_data
);
    initial begin
        conversion_trigger = 1'b0;
        result_read = 1'b0;
        adc_a_data = 16'h0000;
        adc_b_data = 16'h0000;
    end
    // converter output carries the channels of the step in flight
    always @(negedge hclk) begin
        if (conv_start === 1'b1) begin
            adc_a_data <= {12'hA5C, a_side_channel_select};
            adc_b_data <= {11'h3B1, b_side_channel_select};
        end
    end
    task automatic trigger_edge();
        conversion_trigger <= 1'b1;
        @(posedge hclk);
        conversion_trigger <= 1'b0;
    endtask : trigger_edge
    // only called once busy has dropped
    task automatic pop_result(output logic [31:0] d, output logic v);
        @(negedge hclk);
        d = result_data;
        v = result_valid;
        @(posedge hclk);
        result_read <= 1'b1;
        @(posedge hclk);
        result_read <= 1'b0;
    endtask : pop_result
endmodule : asbc_host_model
`default_nettype wire

// File: hw/asbc_seq_top.sv
`timescale 1ns/10ps
`default_nettype none
module asbc_seq_top #(
    parameter int CNT_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic hw_mode_pin,
    input wire logic burst_pin,
    input wire logic seq_enable_pin,
    input wire logic [2:0] channel_range_pins,
    input wire logic conversion_trigger,
    output logic busy,
    output logic conv_start,
    output logic [3:0] a_side_channel_select,
    output logic [4:0] b_side_channel_select,
    input wire logic [15:0] adc_a_data,
    input wire logic [15:0] adc_b_data,
    input wire logic result_read,
    output logic result_valid,
    output logic [31:0] result_data
);
    import asbc_pkg::*;

    localparam int FIRST_L = FIRST_CYC;

    // bus slave state
    asbc_aphase_t aph_r, aph_nxt;
    asbc_cfg_t cfg_r, cfg_nxt;
    asbc_step_t stack_r [STACK_DEPTH];
    logic prst;
    logic stack_we;
    logic [PTR_W-1:0] stack_widx;

    // strap state
    logic strap_done_r, strap_done_nxt;
    logic hw_mode_r, hw_mode_nxt;
    logic hw_burst_r, hw_burst_nxt;
    logic hw_seq_r, hw_seq_nxt;
    logic [2:0] end_pair_r, end_pair_nxt;

    // sequencer state
    asbc_state_t state_r, state_nxt;
    logic [PTR_W-1:0] ptr_r, ptr_nxt;
    logic [2:0] end_act_r, end_act_nxt;
    logic burst_act_r, burst_act_nxt;
    logic trig_prev_r;
    logic start_r, start_nxt;
    logic [5:0] wr_idx_r, wr_idx_nxt;
    logic [5:0] rd_idx_r, rd_idx_nxt;
    logic [31:0] res_mem [STACK_DEPTH];

    logic trig_rise;
    logic seq_on;
    logic burst_on;
    logic last_step;
    logic step_done;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_count;
    asbc_step_t cur_step;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        aph_nxt = aph_r;
        if (hready) begin
            aph_nxt.valid = hsel && htrans[1];
            aph_nxt.write = hwrite;
            aph_nxt.addr = haddr[7:0];
        end
    end

    // data-phase register write
    always_comb begin
        cfg_nxt = cfg_r;
        prst = 1'b0;
        stack_we = 1'b0;
        stack_widx = aph_r.addr[6:2];
        if (aph_r.valid && aph_r.write) begin
            if (aph_r.addr == CFG_OFS) begin
                cfg_nxt.seq_en = hwdata[CFG_SEQ_EN_BIT];
                cfg_nxt.burst = hwdata[CFG_BURST_BIT];
                prst = hwdata[CFG_PRST_BIT];
            end else if (aph_r.addr[7]) begin
                stack_we = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_r <= '0;
            cfg_r <= CFG_RST;
        end else begin
            aph_r <= aph_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_r[i] <= STEP_RST;
            end
        end else if (stack_we) begin
            stack_r[stack_widx] <= hwdata[STEP_W-1:0];
        end
    end

    always_comb begin
        hrdata = '0;
        if (aph_r.valid && !aph_r.write) begin
            if (aph_r.addr == CFG_OFS) begin
                hrdata[CFG_SEQ_EN_BIT] = cfg_r.seq_en;
                hrdata[CFG_BURST_BIT] = cfg_r.burst;
            end else if (aph_r.addr == STAT_OFS) begin
                hrdata[STAT_BUSY_BIT] = busy;
                hrdata[STAT_HW_BIT] = hw_mode_r;
                hrdata[STAT_BURST_BIT] = burst_on;
                hrdata[STAT_SEQ_BIT] = seq_on;
                hrdata[STAT_PTR_LSB +: PTR_W] = ptr_r;
                hrdata[STAT_CNT_LSB +: 6] = wr_idx_r;
                hrdata[STAT_END_LSB +: 3] = end_pair_r;
            end else if (aph_r.addr[7]) begin
                hrdata[STEP_W-1:0] = stack_r[aph_r.addr[6:2]];
            end
        end
    end

    // straps are caught on the first edge after reset release; the end pair is also reloaded from the pins while busy
    always_comb begin
        strap_done_nxt = 1'b1;
        hw_mode_nxt = hw_mode_r;
        hw_burst_nxt = hw_burst_r;
        hw_seq_nxt = hw_seq_r;
        end_pair_nxt = end_pair_r;
        if (!strap_done_r) begin
            hw_mode_nxt = hw_mode_pin;
            hw_seq_nxt = seq_enable_pin;
            hw_burst_nxt = burst_pin && seq_enable_pin;
            end_pair_nxt = channel_range_pins;
        end else if (busy) begin
            end_pair_nxt = channel_range_pins;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done_r <= 1'b0;
            hw_mode_r <= 1'b0;
            hw_burst_r <= 1'b0;
            hw_seq_r <= 1'b0;
            end_pair_r <= '0;
        end else begin
            strap_done_r <= strap_done_nxt;
            hw_mode_r <= hw_mode_nxt;
            hw_burst_r <= hw_burst_nxt;
            hw_seq_r <= hw_seq_nxt;
            end_pair_r <= end_pair_nxt;
        end
    end

    assign seq_on = hw_mode_r ? hw_seq_r : cfg_r.seq_en;
    assign burst_on = hw_mode_r ? hw_burst_r
                                : (cfg_r.burst && cfg_r.seq_en);
    assign trig_rise = conversion_trigger && !trig_prev_r;
    assign cur_step = stack_r[ptr_r];

    // the step that ends the sequence
    always_comb begin
        if (!seq_on) begin
            last_step = 1'b1;
        end else if (hw_mode_r) begin
            last_step = (ptr_r == {2'b00, end_act_r});
        end else begin
            last_step = cur_step.step_end
                        || (ptr_r == PTR_W'(STACK_DEPTH - 1));
        end
    end

    always_comb begin
        a_side_channel_select = '0;
        b_side_channel_select = '0;
        if (seq_on && hw_mode_r) begin
            a_side_channel_select = {1'b0, ptr_r[2:0]};
            b_side_channel_select = {2'b00, ptr_r[2:0]};
        end else if (seq_on) begin
            a_side_channel_select = cur_step.a_sel;
            b_side_channel_select = cur_step.b_sel;
        end
    end

    always_comb begin
        state_nxt = state_r;
        ptr_nxt = ptr_r;
        end_act_nxt = end_act_r;
        burst_act_nxt = burst_act_r;
        start_nxt = 1'b0;
        wr_idx_nxt = wr_idx_r;
        rd_idx_nxt = rd_idx_r;
        tmr_load = 1'b0;
        tmr_count = CNT_W'(FIRST_CYC);
        if (result_read && result_valid) begin
            rd_idx_nxt = rd_idx_r + 6'h01;
        end
        unique case (state_r)
            ST_IDLE: begin
                if (trig_rise && strap_done_r) begin
                    state_nxt = ST_CONV;
                    burst_act_nxt = burst_on;
                    end_act_nxt = end_pair_r;
                    start_nxt = 1'b1;
                    tmr_load = 1'b1;
                    wr_idx_nxt = '0;
                    rd_idx_nxt = '0;
                end
            end
            ST_CONV: begin
                // trigger edges here are not looked at
                if (step_done) begin
                    wr_idx_nxt = wr_idx_r + 6'h01;
                    ptr_nxt = last_step ? '0 : ptr_r + 1'b1;
                    if (burst_act_r && !last_step) begin
                        start_nxt = 1'b1;
                        tmr_load = 1'b1;
                        tmr_count = CNT_W'(NEXT_CYC);
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
        endcase
        if (prst) begin
            state_nxt = ST_IDLE;
            ptr_nxt = '0;
            start_nxt = 1'b0;
            wr_idx_nxt = '0;
            rd_idx_nxt = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            ptr_r <= '0;
            end_act_r <= '0;
            burst_act_r <= 1'b0;
            trig_prev_r <= 1'b0;
            start_r <= 1'b0;
            wr_idx_r <= '0;
            rd_idx_r <= '0;
        end else begin
            state_r <= state_nxt;
            ptr_r <= ptr_nxt;
            end_act_r <= end_act_nxt;
            burst_act_r <= burst_act_nxt;
            trig_prev_r <= conversion_trigger;
            start_r <= start_nxt;
            wr_idx_r <= wr_idx_nxt;
            rd_idx_r <= rd_idx_nxt;
        end
    end

    // results are stored in step order
    always_ff @(posedge hclk) begin
        if (state_r == ST_CONV && step_done && !prst) begin
            res_mem[wr_idx_r[PTR_W-1:0]] <= {adc_a_data, adc_b_data};
        end
    end

    assign busy = (state_r == ST_CONV);
    assign conv_start = start_r;
    assign result_valid = !busy && (rd_idx_r < wr_idx_r);
    assign result_data = res_mem[rd_idx_r[PTR_W-1:0]];

    asbc_step_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(tmr_load),
        .abort(prst),
        .count(tmr_count),
        .done(step_done)
    );

    busy_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == ST_IDLE && trig_rise && strap_done_r && !prst)
        |=> busy && conv_start)
        else $error("busy did not rise on trigger edge");

    first_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(busy) && !prst) |-> ##(FIRST_L - 1) (step_done || !busy))
        else $error("first conversion time wrong");

    ignore_trig_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (busy && trig_rise && !step_done && !prst)
        |=> $stable(ptr_r) && busy)
        else $error("trigger during busy disturbed sequence");

    wrap_ptr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (busy && step_done && last_step) |=> ptr_r == '0)
        else $error("pointer did not wrap after last step");

    burst_go_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (busy && step_done && burst_act_r && !last_step && !prst)
        |=> busy && conv_start && ptr_r == $past(ptr_r) + 1'b1)
        else $error("burst did not continue");

    single_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (busy && step_done && !burst_act_r) |=> !busy)
        else $error("non-burst converted more than one step");

    part_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        prst |=> ptr_r == '0 && !busy && $stable(stack_r[0]))
        else $error("partial reset did not zero pointer");

    strap_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(strap_done_r) |-> $stable(hw_burst_r) && $stable(hw_mode_r))
        else $error("strap setting changed after release");

    hw_burst_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hw_burst_r |-> hw_seq_r)
        else $error("hardware burst without sequencer enable");

    read_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        busy |-> !result_valid)
        else $error("result offered while busy");
endmodule : asbc_seq_top
`default_nettype wire

// File: hw/asbc_step_timer.sv
`timescale 1ns/10ps
`default_nettype none
module asbc_step_timer #(
    parameter int CNT_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic abort,
    input wire logic [CNT_W-1:0] count,
    output logic done
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic run_r;
    logic run_nxt;

    assign done = run_r && (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        if (abort) begin
            run_nxt = 1'b0;
        end else if (load) begin
            cnt_nxt = count;
            run_nxt = 1'b1;
        end else if (done) begin
            run_nxt = 1'b0;
        end else if (run_r) begin
            cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
        end
    end
endmodule : asbc_step_timer
`default_nettype wire

// File: include/asbc_pkg.sv
package asbc_pkg;
    // register byte offsets
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] STACK_BASE = 8'h80;
    localparam int STACK_DEPTH = 32;
    localparam int PTR_W = 5;
    localparam int CNT_W_DEF = 12;

    // configuration register bits
    localparam int CFG_SEQ_EN_BIT = 0;
    localparam int CFG_BURST_BIT = 1;
    localparam int CFG_PRST_BIT = 2;

    // stack entry field positions
    localparam int STEP_A_LSB = 0;
    localparam int STEP_B_LSB = 4;
    localparam int STEP_END_BIT = 9;
    localparam int STEP_W = 10;

    // status register field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_HW_BIT = 1;
    localparam int STAT_BURST_BIT = 2;
    localparam int STAT_SEQ_BIT = 3;
    localparam int STAT_PTR_LSB = 8;
    localparam int STAT_CNT_LSB = 16;
    localparam int STAT_END_LSB = 24;

    // timing
    localparam int CLK_MHZ = 200;
    localparam int T_CONV_NS = 500;
    localparam int T_ACQ_BURST_NS = 250;
    localparam int T_FIRST_EXTRA_NS = 25;
    localparam int FIRST_CYC = ((T_CONV_NS + T_FIRST_EXTRA_NS) * CLK_MHZ
                                + 999) / 1000;
    localparam int NEXT_CYC = ((T_CONV_NS + T_ACQ_BURST_NS) * CLK_MHZ
                               + 999) / 1000;

    typedef struct packed {
        logic step_end;
        logic [4:0] b_sel;
        logic [3:0] a_sel;
    } asbc_step_t;

    typedef struct packed {
        logic burst;
        logic seq_en;
    } asbc_cfg_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } asbc_aphase_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } asbc_state_t;

    localparam asbc_cfg_t CFG_RST = '0;
    localparam asbc_step_t STEP_RST = '0;
endpackage : asbc_pkg
